// ### verilog/sfr_top.sv
// Serial slave port and fault-response logic of a motor predriver.
// Assumes error inputs and control strobes on mclk, link pins from an
// external master, and a link clock that stops while chip select is high.
`timescale 1ns/1ps

module sfr_top
#(
  parameter int unsigned MCU_PULSE_LEN = sfr_pkg::MCU_PULSE_CYCLES
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable_pin,
  input wire sfr_pkg::sfr_errors_t errors,
  input wire logic wdt_error_pulse,
  input wire logic otp_busy,
  input wire logic [1:0] operating_state,
  input wire logic dead_time_load,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  output logic fault_indicator_pin,
  output sfr_pkg::sfr_power_t power,
  output logic mcu_reset_output,
  output logic [3:0] dynamic_dead_time,
  output logic otp_download_start,
  output logic watchdog_restart
);
  import sfr_pkg::*;

  // Link side state
  logic [15:0] rx_q;
  logic [4:0] edge_cnt_q;
  logic sdi_rise_q;
  logic phase_err_q;
  logic sdo_q;
  logic [7:0] rd_q;
  logic [7:0] rd_now;
  logic [15:0] word_q;
  logic [4:0] cnt_q;
  logic perr_q;

  // System side state
  logic cs_meta_q, cs_sync_q, cs_prev_q;
  logic en_meta_q, en_sync_q;
  sfr_snap_t snap_q, snap_d;
  sfr_errors_t flags_q;
  logic [7:0] conf0_q, conf1_q, conf2_q, conf7_q, orb_q;
  logic [3:0] dead_q;
  logic dead_pending_q, main_lock_q, otp_lock_q, latch_q, acc_fail_q;
  logic [15:0] wdt_cnt_q;
  logic oe_n_q, pin_q, mcu_res_q, dl_q, wdr_q;
  sfr_power_t power_q;

  // Readback of the frozen copy, chosen by the received address
  function automatic logic [7:0] read_reg(input logic [6:0] a,
                                          input sfr_snap_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_CONF0: v = s.conf0;
      ADDR_CONF1: v = s.conf1;
      ADDR_CONF2: v = s.conf2;
      ADDR_CONF3: v = {7'h00, s.otp_lock};
      ADDR_CONF7: v = s.conf7;
      ADDR_CONF8: v = {7'h00, s.main_lock};
      ADDR_DEAD: v = s.dead;
      ADDR_DEADF: v = {7'h00, s.dead_pending};
      ADDR_ORB: v = s.orb;
      ADDR_DIAGA: v = s.fault_indicator_pin_a;
      ADDR_DIAGB: v = s.fault_indicator_pin_b;
      ADDR_ACK: v = ACK_VALUE;
      ADDR_OTP_HI: v = {7'h00, s.otp_lock};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Assigned addresses; unlisted ones answer with an access failure
  function automatic logic addr_valid(input logic [6:0] a);
    return (a <= ADDR_CONF8) ||
           (a >= ADDR_AOSEL && a <= ADDR_ODL) ||
           (a >= ADDR_DIAGA && a <= ADDR_ACK) ||
           (a >= ADDR_OTP_LO && a <= ADDR_OTP_HI);
  endfunction

  // Rising edge: shift in MSB first, count edges, keep the sampled bit
  always_ff @(posedge sclk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      rx_q <= 16'h0000;
      edge_cnt_q <= 5'h00;
      sdi_rise_q <= 1'b0;
    end
    else
    begin
      rx_q <= {rx_q[14:0], sdi};
      sdi_rise_q <= sdi;
      if (edge_cnt_q != EDGE_SAT)
        edge_cnt_q <= edge_cnt_q + 5'h01;
    end
  end

  assign rd_now = read_reg(rx_q[6:0], snap_q);

  // Falling edge: drive next bit and check the input held since rising edge
  always_ff @(negedge sclk or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      sdo_q <= 1'b0;
      rd_q <= 8'h00;
      phase_err_q <= 1'b0;
    end
    else
    begin
      if (sdi != sdi_rise_q)
        phase_err_q <= 1'b1;
      if (edge_cnt_q == READ_EDGE)
      begin
        rd_q <= rd_now;
        sdo_q <= rd_now[7];
      end
      else if (edge_cnt_q < READ_EDGE)
        sdo_q <= snap_q.status[~edge_cnt_q[2:0]];
      else if (edge_cnt_q < WORD_EDGES)
        sdo_q <= rd_q[~edge_cnt_q[2:0]];
      else
        sdo_q <= 1'b0;
    end
  end

  // Word, edge count and phase flag caught as chip select rises; the
  // level clear above lands only after this edge has sampled them
  always_ff @(posedge chip_select_n)
  begin
    word_q <= rx_q;
    cnt_q <= edge_cnt_q;
    perr_q <= phase_err_q;
  end

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      en_meta_q <= 1'b0;
      en_sync_q <= 1'b0;
    end
    else
    begin
      cs_meta_q <= chip_select_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      en_meta_q <= enable_pin;
      en_sync_q <= en_meta_q;
    end
  end

  // Word decode, valid only at the commit strobe when the link is stopped
  logic commit, spi_off, wen, err, do_write, do_read;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic ro, locked, busy_err, dead_err;

  assign spi_off = !mcu_res_q || operating_state == STATE_STARTUP;
  assign commit = cs_sync_q && !cs_prev_q && !spi_off;
  assign wen = word_q[15];
  assign addr = word_q[14:8];
  assign wdata = word_q[7:0];
  assign ro = addr == ADDR_CONF3 || addr == ADDR_DEADF ||
              (addr >= ADDR_DIAGA && addr <= ADDR_ACK);
  assign locked = (main_lock_q && addr >= ADDR_MAIN_LO &&
                   addr <= ADDR_CONF7) ||
                  (otp_lock_q && ((addr >= ADDR_OTP_LO &&
                   addr <= ADDR_OTP_HI) || addr <= ADDR_CONF2));
  assign busy_err = otp_busy && ((addr <= ADDR_CONF8) ||
                    (addr >= ADDR_OTP_LO && addr <= ADDR_OTP_HI) ||
                    (wen && addr == ADDR_ODL));
  assign dead_err = wen && addr == ADDR_DEAD && dead_pending_q;
  assign err = !addr_valid(addr) || cnt_q != WORD_EDGES ||
               perr_q || (wen && (ro || locked)) ||
               busy_err || dead_err;
  assign do_write = commit && !err && wen;
  assign do_read = commit && !err && !wen;

  // Failure of the previous access, refreshed on each committed word
  always_ff @(posedge mclk)
  begin
    if (reset)
      acc_fail_q <= 1'b0;
    else if (commit)
      acc_fail_q <= err;
  end

  // Writable configuration; locks are one-way
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      conf0_q <= CONF_RESET;
      conf1_q <= CONF_RESET;
      conf2_q <= CONF_RESET;
      conf7_q <= CONF_RESET;
      orb_q <= CONF_RESET;
      main_lock_q <= 1'b0;
      otp_lock_q <= 1'b0;
    end
    else if (do_write)
    begin
      unique case (addr)
        ADDR_CONF0: conf0_q <= wdata;
        ADDR_CONF1: conf1_q <= wdata;
        ADDR_CONF2: conf2_q <= wdata;
        ADDR_CONF7: conf7_q <= wdata;
        ADDR_ORB: orb_q <= wdata;
        ADDR_CONF8: main_lock_q <= main_lock_q | wdata[LOCK_BIT];
        ADDR_OTP_HI: otp_lock_q <= otp_lock_q | wdata[LOCK_BIT];
        default: ;
      endcase
    end
  end

  // Dead time value and its pending flag; a write beats a same-cycle upload
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      dead_q <= DEAD_RESET;
      dead_pending_q <= 1'b0;
    end
    else if (do_write && addr == ADDR_DEAD)
    begin
      dead_q <= wdata[3:0];
      dead_pending_q <= 1'b1;
    end
    else if (dead_time_load)
      dead_pending_q <= 1'b0;
  end

  // Command strobes, one cycle each
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      dl_q <= 1'b0;
      wdr_q <= 1'b0;
    end
    else
    begin
      dl_q <= do_write && addr == ADDR_ODL && wdata == CMD_DOWNLOAD;
      wdr_q <= do_write && addr == ADDR_RSTCMD &&
               wdata == CMD_WDT_RESTART;
    end
  end

  // Sticky fault_indicator_pin flags, kept until software reads them; a new error wins
  always_ff @(posedge mclk)
  begin
    if (reset)
      flags_q <= '0;
    else
    begin
      flags_q[9:5] <= errors[9:5] | ({wdt_error_pulse, 4'h0}) |
        (flags_q[9:5] & ~{5{do_read && addr == ADDR_DIAGA}});
      flags_q[4:0] <= errors[4:0] |
        (flags_q[4:0] & ~{5{do_read && addr == ADDR_DIAGB}});
    end
  end

  // Shutdown latch for overcurrent and FET short
  logic latch_set, latch_clear;
  assign latch_set = en_sync_q &&
    ((errors.oc && conf7_q[5:4] == REACT_LATCH) ||
     (errors.fs && conf7_q[7:6] == REACT_LATCH));
  assign latch_clear = !en_sync_q ||
    (do_write && addr == ADDR_RSTCMD && wdata == CMD_LATCH_CLEAR);

  always_ff @(posedge mclk)
  begin
    if (reset)
      latch_q <= 1'b0;
    else if (latch_set)
      latch_q <= 1'b1;
    else if (latch_clear)
      latch_q <= 1'b0;
  end

  // Watchdog reset pulse; a new error restarts the full length
  always_ff @(posedge mclk)
  begin
    if (reset)
      wdt_cnt_q <= 16'h0000;
    else if (wdt_error_pulse && conf1_q[WDT_SEL_BIT])
      wdt_cnt_q <= 16'(MCU_PULSE_LEN);
    else if (wdt_cnt_q != 16'h0000)
      wdt_cnt_q <= wdt_cnt_q - 16'h0001;
  end

  // Reaction terms; supply codes with bit 1 set mean auto recover
  logic sup_off, ocfs_off, ths_auto, wdt_auto, alarm;
  assign sup_off = (errors.vsuv && conf2_q[1]) ||
                   (errors.vsov && conf2_q[3]) ||
                   (errors.vdov && conf2_q[5]) ||
                   (errors.vguv && conf1_q[1]);
  assign ocfs_off = (errors.oc && conf7_q[5:4] == REACT_AUTO) ||
                    (errors.fs && conf7_q[7:6] == REACT_AUTO) ||
                    latch_q;
  assign ths_auto = errors.ths && conf1_q[THS_SEL_BIT];
  assign wdt_auto = wdt_cnt_q != 16'h0000;
  // Masked errors stay flagged but never reach the pin
  assign alarm =
    (flags_q.vsuv && conf2_q[1:0] != REACT_MASK) ||
    (flags_q.vsov && conf2_q[3:2] != REACT_MASK) ||
    (flags_q.vdov && conf2_q[5:4] != REACT_MASK) ||
    (flags_q.vguv && conf1_q[1:0] != REACT_MASK) ||
    (flags_q.oc && conf7_q[5:4] != REACT_MASK) ||
    (flags_q.fs && conf7_q[7:6] != REACT_MASK) ||
    (flags_q.thw && conf1_q[THW_SEL_BIT]) ||
    (flags_q.ths && conf1_q[THS_SEL_BIT]) ||
    (flags_q.wdt && conf1_q[WDT_SEL_BIT]);

  // Power stage, MCU reset and fault pin, all registered
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      power_q <= '0;
      mcu_res_q <= 1'b1;
      pin_q <= 1'b1;
    end
    else
    begin
      power_q.gate_drive_en <= en_sync_q && !sup_off && !ocfs_off &&
        !ths_auto && !wdt_auto && !errors.vcuv;
      power_q.gate_drive_supply <= !ths_auto;
      power_q.regulator_en <= !ths_auto;
      mcu_res_q <= !(ths_auto || wdt_auto || errors.vcuv);
      pin_q <= alarm ~^ conf0_q[POL_BIT];
    end
  end

  // Output enable follows synced chip select; low means driving
  always_ff @(posedge mclk)
  begin
    if (reset)
      oe_n_q <= 1'b1;
    else
      oe_n_q <= cs_sync_q || spi_off;
  end

  // Frozen copy for the link, refreshed only while chip select is high
  always_comb
  begin
    snap_d = snap_q;
    snap_d.status = {1'b0, orb_q[MARGIN_BIT], acc_fail_q,
                     |flags_q, latch_q, otp_busy,
                     operating_state};
    snap_d.conf0 = conf0_q;
    snap_d.conf1 = conf1_q;
    snap_d.conf2 = conf2_q;
    snap_d.conf7 = conf7_q;
    snap_d.dead = {4'h0, dead_q};
    snap_d.orb = orb_q;
    snap_d.fault_indicator_pin_a = {3'h0, flags_q[9:5]};
    snap_d.fault_indicator_pin_b = {3'h0, flags_q[4:0]};
    snap_d.main_lock = main_lock_q;
    snap_d.otp_lock = otp_lock_q;
    snap_d.dead_pending = dead_pending_q;
  end

  // Holding still during the frame keeps the link from seeing a moving word
  always_ff @(posedge mclk)
  begin
    if (reset)
      snap_q <= '0;
    else if (cs_sync_q)
      snap_q <= snap_d;
  end

  assign sdo = sdo_q;
  assign sdo_oe_n = oe_n_q;
  assign fault_indicator_pin = pin_q;
  assign power = power_q;
  assign mcu_reset_output = mcu_res_q;
  assign dynamic_dead_time = dead_q;
  assign otp_download_start = dl_q;
  assign watchdog_restart = wdr_q;

endmodule

// ### verilog/sfr_pkg.sv
// Constants, field layouts and carrier types for the serial status port
// and fault-response logic. Assumes one system clock and a serial link
// clock that runs only while chip select is low.
// Functional notes
// - Every detected error sets its fault_indicator_pin flag and shows in the status byte.
// - Unmasked errors except vcuv toggle the fault pin; polarity comes from a config bit.
// - Overcurrent and FET-short latch only when their latch option is set.
// - A latch holds drivers off until reset, enable low or FFh command.
// - Supply, overcurrent, FET-short: drivers on for report/ignore, else off.
// - Thermal shutdown auto-recover turns supplies off; watchdog drivers too.
// - Thermal shutdown auto-recover pulls the MCU reset low.
// - Watchdog auto-recover emits a low MCU reset pulse.
// - Words shift most significant bit first with active-high levels.
// - Data changes on falling clock edges and is sampled on rising ones.
// - First byte out is status; bit 7 zero, bits 1:0 operating state.
// - Status bit 2 shows an OTP download in progress.
// - Status bit 6 shows OTP margin test mode.
// - Status bit 5 shows that the previous access failed.
// - Unassigned addresses and writes to read-only or locked regs fail.
// - A word with other than 16 clock edges fails.
// - While OTP busy, config access or download command writes fail.
// - Locks make writes to 04h-07h or 40h-43h fail.
// - Input change between a rising and the next falling clock edge is a phase error.
// - Writing the dead time while its upload is pending fails.
// - Port idle before OTP download ends and while MCU reset is low.
// - Dead-time pending flag holds from write until counter upload.

package sfr_pkg;

  // Register addresses
  localparam logic [6:0] ADDR_CONF0 = 7'h00;
  localparam logic [6:0] ADDR_CONF1 = 7'h01;
  localparam logic [6:0] ADDR_CONF2 = 7'h02;
  localparam logic [6:0] ADDR_CONF3 = 7'h03;
  localparam logic [6:0] ADDR_MAIN_LO = 7'h04;
  localparam logic [6:0] ADDR_CONF7 = 7'h07;
  localparam logic [6:0] ADDR_CONF8 = 7'h08;
  localparam logic [6:0] ADDR_AOSEL = 7'h10;
  localparam logic [6:0] ADDR_FSDL = 7'h12;
  localparam logic [6:0] ADDR_DEAD = 7'h13;
  localparam logic [6:0] ADDR_DEADF = 7'h14;
  localparam logic [6:0] ADDR_RSTCMD = 7'h15;
  localparam logic [6:0] ADDR_ORB = 7'h16;
  localparam logic [6:0] ADDR_ODL = 7'h17;
  localparam logic [6:0] ADDR_DIAGA = 7'h20;
  localparam logic [6:0] ADDR_DIAGB = 7'h21;
  localparam logic [6:0] ADDR_ACK = 7'h22;
  localparam logic [6:0] ADDR_OTP_LO = 7'h40;
  localparam logic [6:0] ADDR_OTP_HI = 7'h43;

  // Command and fixed values
  localparam logic [7:0] CMD_LATCH_CLEAR = 8'hFF;
  localparam logic [7:0] CMD_WDT_RESTART = 8'h00;
  localparam logic [7:0] CMD_DOWNLOAD = 8'h00;
  localparam logic [7:0] ACK_VALUE = 8'h55;
  localparam logic [7:0] CONF_RESET = 8'h00;
  localparam logic [3:0] DEAD_RESET = 4'h0;

  // Field positions
  localparam int POL_BIT = 2;
  localparam int THS_SEL_BIT = 3;
  localparam int THW_SEL_BIT = 2;
  localparam int WDT_SEL_BIT = 4;
  localparam int LOCK_BIT = 0;
  localparam int MARGIN_BIT = 1;
  localparam int ST_MARGIN = 6;
  localparam int ST_ACC_FAIL = 5;
  localparam int ST_FAIL = 4;
  localparam int ST_LATCH = 3;
  localparam int ST_BUSY = 2;

  // Two-bit reaction codes
  localparam logic [1:0] REACT_MASK = 2'h0;
  localparam logic [1:0] REACT_REPORT = 2'h1;
  localparam logic [1:0] REACT_AUTO = 2'h2;
  localparam logic [1:0] REACT_LATCH = 2'h3;

  // Operating state codes
  localparam logic [1:0] STATE_STARTUP = 2'h1;

  // Word framing
  localparam logic [4:0] WORD_EDGES = 5'h10;
  localparam logic [4:0] EDGE_SAT = 5'h1F;
  localparam logic [4:0] READ_EDGE = 5'h08;

  // Watchdog reset pulse length
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MCU_PULSE_US = 400;
  localparam int unsigned MCU_PULSE_CYCLES =
    MCU_PULSE_US * 1000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic wdt;
    logic ths;
    logic thw;
    logic fs;
    logic oc;
    logic vcuv;
    logic vguv;
    logic vdov;
    logic vsov;
    logic vsuv;
  } sfr_errors_t;

  typedef struct packed {
    logic gate_drive_supply;
    logic gate_drive_en;
    logic regulator_en;
  } sfr_power_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] conf0;
    logic [7:0] conf1;
    logic [7:0] conf2;
    logic [7:0] conf7;
    logic [7:0] dead;
    logic [7:0] orb;
    logic [7:0] fault_indicator_pin_a;
    logic [7:0] fault_indicator_pin_b;
    logic main_lock;
    logic otp_lock;
    logic dead_pending;
  } sfr_snap_t;

endpackage

// ### bench/sfr_sva.sv
// Checker for the serial status port and fault reactions.
// Assumes binding to sfr_top; sees only that module's ports.
`timescale 1ns/1ps

module sfr_sva
#(
  parameter int unsigned MCU_PULSE_LEN = 20
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable_pin,
  input wire sfr_pkg::sfr_errors_t errors,
  input wire logic wdt_error_pulse,
  input wire logic otp_busy,
  input wire logic [1:0] operating_state,
  input wire logic dead_time_load,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic fault_indicator_pin,
  input wire sfr_pkg::sfr_power_t power,
  input wire logic mcu_reset_output,
  input wire logic [3:0] dynamic_dead_time,
  input wire logic otp_download_start,
  input wire logic watchdog_restart
);
  import sfr_pkg::*;
  logic [31:0] low_cnt_q;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Low time of the MCU reset not owed to a thermal or supply fault
  always_ff @(posedge mclk)
  begin
    if (reset || mcu_reset_output || errors.ths || errors.vcuv)
      low_cnt_q <= '0;
    else
      low_cnt_q <= low_cnt_q + 32'h1;
  end

  // Framing and port enable; the syncs allow a few mclk of lag
  a_oe_idle_high: assert property (chip_select_n [*5] |-> sdo_oe_n)
    else $error("output enabled outside a frame");
  a_sdo_quiet: assert property (chip_select_n |-> !sdo)
    else $error("serial out not quiet outside a frame");
  a_oe_on_frame: assert property
    ($fell(chip_select_n) && mcu_reset_output &&
     operating_state != STATE_STARTUP |-> ##[1:4] !sdo_oe_n)
    else $error("port did not drive in a frame");
  a_port_mcu_off: assert property
    (!mcu_reset_output [*4] |-> sdo_oe_n)
    else $error("port active during MCU reset");
  a_port_start_off: assert property
    ((operating_state == STATE_STARTUP) [*4] |-> sdo_oe_n)
    else $error("port active during start-up");

  // Fault reactions
  a_pulse_bound: assert property (low_cnt_q <= MCU_PULSE_LEN + 4)
    else $error("MCU reset pulse too long");
  a_vcuv_force: assert property
    (errors.vcuv [*3] |-> !mcu_reset_output && !power.gate_drive_en)
    else $error("supply fault did not stop drivers");
  a_en_low_off: assert property
    (!enable_pin [*5] |-> !power.gate_drive_en)
    else $error("drivers on with enable low");

  // Register effects only after a whole word has been framed
  a_strobe_after_frame: assert property
    ($rose(watchdog_restart) || $rose(otp_download_start)
     |-> $past(chip_select_n, 2))
    else $error("command strobe inside a frame");
  a_dead_after_frame: assert property
    ($changed(dynamic_dead_time) |-> $past(chip_select_n, 2))
    else $error("dead time changed inside a frame");
endmodule

bind sfr_top sfr_sva #(.MCU_PULSE_LEN(MCU_PULSE_LEN)) sva_u
(
  .mclk(mclk), .reset(reset), .enable_pin(enable_pin), .errors(errors),
  .wdt_error_pulse(wdt_error_pulse), .otp_busy(otp_busy),
  .operating_state(operating_state), .dead_time_load(dead_time_load),
  .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo),
  .sdo_oe_n(sdo_oe_n), .fault_indicator_pin(fault_indicator_pin),
  .power(power), .mcu_reset_output(mcu_reset_output),
  .dynamic_dead_time(dynamic_dead_time),
  .otp_download_start(otp_download_start),
  .watchdog_restart(watchdog_restart)
);

// ### bench/sfr_spi_master.sv
// SPI master model: one 16-bit full-duplex word per chip select.
// Assumes the caller spaces frames; link clock 32 ns, still between frames.
`timescale 1ns/1ps

module sfr_spi_master
(
  output logic sclk,
  output logic chip_select_n,
  output logic sdi,
  input wire logic sdo
);
  // Clock idles low so the leading edge rises
  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
  end

  // Edge counts other than 16 or a skewed bit break the word on purpose
  task automatic xfer(input logic [15:0] w, input int edges, input bit skew,
    output logic [15:0] reply);
    reply = '0;
    chip_select_n = 1'b0;
    #80;
    for (int i = 0; i < edges; i++)
    begin
      // Change just after the fall so the fall-edge phase check sees it held
      #2;
      sdi = w[15 - (i % 16)];
      #14;
      sclk = 1'b1;
      reply = {reply[14:0], sdo};
      if (skew && i == 3)
      begin
        #8;
        sdi = ~sdi;
        #8;
      end
      else
        #16;
      sclk = 1'b0;
    end
    #16;
    chip_select_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale value
    #100;
  endtask
endmodule

// ### bench/sfr_top_test.sv
// Self-checking bench for the serial status port and fault reactions.
// Assumes the master model in sfr_spi_master and a 100 MHz mclk.
`timescale 1ns/1ps

module sfr_top_test;
  import sfr_pkg::*;
  localparam int unsigned PULSE = 20;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic enable_pin = 1'b0;
  sfr_errors_t errors = '0;
  logic wdt_error_pulse = 1'b0;
  logic otp_busy = 1'b0;
  logic [1:0] operating_state = 2'h3;
  logic dead_time_load = 1'b0;
  logic sclk, chip_select_n, sdi, sdo, sdo_oe_n, sdo_line;
  logic fault_indicator_pin, mcu_reset_output;
  logic otp_download_start, watchdog_restart;
  sfr_power_t power;
  logic [3:0] dynamic_dead_time;
  logic [15:0] rep;
  int failures = 0;
  int cmp_count = 0;
  int dl_seen = 0;
  int wdr_seen = 0;

  // Released line reads as the inverse of the last bit
  assign sdo_line = sdo_oe_n ? ~sdo : sdo;

  sfr_top #(.MCU_PULSE_LEN(PULSE)) dut_u
  (
    .mclk(mclk), .reset(reset), .enable_pin(enable_pin), .errors(errors),
    .wdt_error_pulse(wdt_error_pulse), .otp_busy(otp_busy),
    .operating_state(operating_state), .dead_time_load(dead_time_load),
    .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .fault_indicator_pin(fault_indicator_pin),
    .power(power), .mcu_reset_output(mcu_reset_output),
    .dynamic_dead_time(dynamic_dead_time),
    .otp_download_start(otp_download_start),
    .watchdog_restart(watchdog_restart)
  );

  sfr_spi_master master_u
  (
    .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo_line)
  );

  always #5 mclk = ~mclk;

  // Command strobes counted as they pass
  always @(posedge mclk)
  begin
    if (otp_download_start === 1'b1)
      dl_seen++;
    if (watchdog_restart === 1'b1)
      wdr_seen++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One word; the model leaves ample gap for commit and snapshot
  task automatic xfer(input logic [15:0] w, input int edges, input bit skew);
    master_u.xfer(w, edges, skew, rep);
    tick(1);
  endtask

  // A refused word flags the next status only
  task automatic bad_case(input logic [15:0] w, input int edges,
    input bit skew);
    xfer(w, edges, skew);
    xfer(16'h2200, 16, 1'b0);
    check("access_fail", 16'(rep[13]), 16'h1);
    xfer(16'h2200, 16, 1'b0);
    check("access_ok", 16'(rep[13]), 16'h0);
  endtask

  task automatic s_status;
    xfer(16'h2200, 16, 1'b0);
    check("status", 16'(rep[15:8]), 16'h03);
    check("ack", 16'(rep[7:0]), 16'(ACK_VALUE));
    otp_busy = 1'b1;
    tick(4);
    xfer(16'h2200, 16, 1'b0);
    check("otp_busy", 16'(rep[10]), 16'h1);
    bad_case(16'h0000, 16, 1'b0);
    bad_case(16'h9700, 16, 1'b0);
    otp_busy = 1'b0;
    xfer(16'h9602, 16, 1'b0);
    xfer(16'h2200, 16, 1'b0);
    check("margin", 16'(rep[14]), 16'h1);
    xfer(16'h9600, 16, 1'b0);
  endtask

  task automatic s_errors;
    bad_case(16'h3000, 16, 1'b0);
    bad_case(16'h8300, 16, 1'b0);
    bad_case(16'h2200, 15, 1'b0);
    bad_case(16'h2200, 16, 1'b1);
    xfer(16'h9500, 16, 1'b0);
    xfer(16'h9700, 16, 1'b0);
    check("download_count", 16'(dl_seen), 16'h1);
  endtask

  task automatic s_dead;
    xfer(16'h9305, 16, 1'b0);
    check("dead_time", 16'(dynamic_dead_time), 16'h5);
    xfer(16'h1400, 16, 1'b0);
    check("pending", 16'(rep[0]), 16'h1);
    bad_case(16'h9307, 16, 1'b0);
    check("dead_kept", 16'(dynamic_dead_time), 16'h5);
    dead_time_load = 1'b1;
    tick(1);
    dead_time_load = 1'b0;
    xfer(16'h1400, 16, 1'b0);
    check("pending_clr", 16'(rep[0]), 16'h0);
    xfer(16'h9307, 16, 1'b0);
    check("dead_new", 16'(dynamic_dead_time), 16'h7);
  endtask

  task automatic s_wdt(input logic sel, input logic pol);
    int cnt;
    cnt = 0;
    xfer({8'h80, 5'h0, pol, 2'h0}, 16, 1'b0);
    xfer({8'h81, 3'h0, sel, 4'h0}, 16, 1'b0);
    check("pin_idle", 16'(fault_indicator_pin), 16'(!pol));
    wdt_error_pulse = 1'b1;
    tick(1);
    wdt_error_pulse = 1'b0;
    repeat (PULSE + 20)
    begin
      if (mcu_reset_output === 1'b0)
        cnt++;
      tick(1);
    end
    check("reset_low", 16'(cnt), sel ? 16'(PULSE) : 16'h0);
    check("pin", 16'(fault_indicator_pin), 16'(sel ? pol : !pol));
    xfer(16'h2000, 16, 1'b0);
    check("flag_wdt", 16'(rep[4]), 16'h1);
    check("fail_bit", 16'(rep[12]), 16'h1);
  endtask

  // Overcurrent with latch, then report, then auto-recover
  task automatic s_latch;
    xfer(16'h8730, 16, 1'b0);
    enable_pin = 1'b1;
    tick(6);
    check("drv_on", 16'(power.gate_drive_en), 16'h1);
    errors.oc = 1'b1;
    tick(3);
    errors.oc = 1'b0;
    tick(6);
    check("drv_latched", 16'(power.gate_drive_en), 16'h0);
    xfer(16'h2200, 16, 1'b0);
    check("latch_bit", 16'(rep[11]), 16'h1);
    xfer(16'h95FF, 16, 1'b0);
    check("drv_freed", 16'(power.gate_drive_en), 16'h1);
    xfer(16'h8710, 16, 1'b0);
    errors.oc = 1'b1;
    tick(3);
    check("drv_report", 16'(power.gate_drive_en), 16'h1);
    errors.oc = 1'b0;
    xfer(16'h8720, 16, 1'b0);
    errors.oc = 1'b1;
    tick(3);
    check("drv_auto", 16'(power.gate_drive_en), 16'h0);
    errors.oc = 1'b0;
    tick(3);
    check("drv_back", 16'(power.gate_drive_en), 16'h1);
    enable_pin = 1'b0;
  endtask

  task automatic s_ths;
    xfer(16'h8108, 16, 1'b0);
    errors.ths = 1'b1;
    tick(6);
    check("ths_reset", 16'(mcu_reset_output), 16'h0);
    check("ths_power", 16'(power), 16'h0);
    errors.ths = 1'b0;
    tick(PULSE + 10);
    check("ths_back", 16'(mcu_reset_output), 16'h1);
    errors.vcuv = 1'b1;
    tick(5);
    errors.vcuv = 1'b0;
    tick(PULSE + 10);
  endtask

  // Start-up keeps the port released and deaf; standby shows in status
  task automatic s_mode;
    operating_state = STATE_STARTUP;
    tick(4);
    xfer(16'h9500, 16, 1'b0);
    check("port_off", 16'(rep[15]), 16'h1);
    check("restart_count", 16'(wdr_seen), 16'h1);
    operating_state = 2'h2;
    tick(4);
    xfer(16'h2200, 16, 1'b0);
    check("standby", 16'(rep[9:8]), 16'h2);
    operating_state = 2'h3;
  endtask

  // Main sequence after a five-cycle reset
  initial
  begin
    tick(5);
    reset = 1'b0;
    tick(5);
    s_status();
    s_errors();
    s_dead();
    s_wdt(1'b0, 1'b0);
    s_wdt(1'b1, 1'b0);
    s_wdt(1'b1, 1'b1);
    s_latch();
    s_ths();
    xfer(16'h8801, 16, 1'b0);
    bad_case(16'h8730, 16, 1'b0);
    xfer(16'hC301, 16, 1'b0);
    bad_case(16'hC000, 16, 1'b0);
    s_mode();
    wrap_up();
  end

  // Hang guard
  initial
  begin
    #900000;
    failures++;
    wrap_up();
  end
endmodule
